// ---- rtl/adccc_pkg.sv ----
// Purpose: Shared constants and types for the converter control block.
// Assumes: 8-bit registers on a plain strobe port.
// Notes: Register offsets are word indices on the local port.
package adccc_pkg;
    // ----------------------------------------------------------------
    // Register offsets
    // ----------------------------------------------------------------
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_CFG = 4'h1;
    localparam logic [3:0] OFS_RES_HI = 4'h2;
    localparam logic [3:0] OFS_RES_LO = 4'h3;
    localparam logic [3:0] OFS_FLAGS = 4'h4;
    localparam logic [3:0] OFS_ENABLES = 4'h5;
    localparam logic [3:0] OFS_PRIORITY = 4'h6;
    localparam logic [3:0] OFS_PORT_A = 4'h7;
    localparam logic [3:0] OFS_PORT_E = 4'h8;
    localparam logic [3:0] OFS_DIR_A = 4'h9;
    localparam logic [3:0] OFS_DIR_E = 4'ha;
    localparam logic [3:0] OFS_CMP2_MODE = 4'hb;
    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_POWER_BIT = 0;
    localparam int CTRL_GO_BIT = 2;
    localparam int CTRL_CHAN_LSB = 3;
    localparam int CTRL_CLK_LSB = 6;
    localparam int CFG_CLK_HI_BIT = 6;
    localparam int CFG_JUSTIFY_BIT = 7;
    localparam int FLAG_DONE_BIT = 6;
    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [7:0] DIR_A_RST = 8'h7f;
    localparam logic [7:0] DIR_E_RST = 8'h07;
    localparam logic [3:0] CMP2_MODE_RST = 4'h0;
    localparam logic [3:0] CMP2_TRIGGER_MODE = 4'hb;
    // ----------------------------------------------------------------
    // Timing counts, in conversion bit periods
    // ----------------------------------------------------------------
    localparam logic [3:0] CONV_PERIODS = 4'hc;
    localparam logic [3:0] ABORT_WAIT_PERIODS = 4'h2;
    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] wdata;
        logic [3:0] addr;
        logic wr;
        logic rd;
    } adccc_bus_t;

    typedef struct packed {
        logic [9:0] result;
        logic done;
        logic abort_done;
    } adccc_evt_t;

    typedef enum logic [1:0] {
        ADCCC_IDLE,
        ADCCC_CONVERT,
        ADCCC_HOLDOFF
    } adccc_state_t;
endpackage

// ---- rtl/adccc_tick_gen.sv ----
// Purpose: Conversion bit period enable from the oscillator divider.
// Assumes: RC oscillator arrives as a level, sampled synchronously.
// Notes: Codes 3 and 7 select the private RC source.
`timescale 1ns/1ps
`default_nettype none
module adccc_tick_gen #(
    parameter int DIV_W = 6
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic run,
    input wire logic [2:0] clk_sel,
    input wire logic rc_osc,
    output logic tick
);
    logic [DIV_W-1:0] cnt_q, cnt_d, last;
    logic rc_s1_q, rc_s2_q, rc_s3_q;
    logic tick_d;

    always_comb begin
        unique case (clk_sel)
            3'b000: last = 6'd1;
            3'b100: last = 6'd3;
            3'b001: last = 6'd7;
            3'b101: last = 6'd15;
            3'b010: last = 6'd31;
            3'b110: last = 6'd63;
            default: last = 6'd0;
        endcase
    end

    always_comb begin
        cnt_d = cnt_q;
        tick_d = 1'b0;
        if (!run) begin
            cnt_d = '0;
        end else if (clk_sel[1:0] == 2'b11) begin
            tick_d = rc_s2_q & ~rc_s3_q;
        end else if (cnt_q >= last) begin
            cnt_d = '0;
            tick_d = 1'b1;
        end else begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= '0;
            rc_s1_q <= 1'b0;
            rc_s2_q <= 1'b0;
            rc_s3_q <= 1'b0;
            tick <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            rc_s1_q <= rc_osc;
            rc_s2_q <= rc_s1_q;
            rc_s3_q <= rc_s2_q;
            tick <= tick_d;
        end
    end
endmodule // adccc_tick_gen
`default_nettype wire

// ---- rtl/adccc_seq.sv ----
// Purpose: Conversion sequencer counting bit periods.
// Assumes: Tick is a one-cycle enable.
// Notes: Reports completion and end of abort wait as pulses.
`timescale 1ns/1ps
`default_nettype none
module adccc_seq (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic tick,
    input wire logic start,
    input wire logic abort,
    input wire logic [9:0] sar_code,
    output adccc_pkg::adccc_evt_t evt,
    output logic busy,
    output logic acquiring
);
    adccc_pkg::adccc_state_t st_q, st_d;
    logic [3:0] cnt_q, cnt_d;
    adccc_pkg::adccc_evt_t evt_d;

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        evt_d = '0;
        unique case (st_q)
            adccc_pkg::ADCCC_IDLE: begin
                if (start) begin
                    st_d = adccc_pkg::ADCCC_CONVERT;
                    cnt_d = '0;
                end
            end
            adccc_pkg::ADCCC_CONVERT: begin
                if (abort) begin
                    st_d = adccc_pkg::ADCCC_HOLDOFF;
                    cnt_d = '0;
                end else if (tick) begin
                    if (cnt_q == adccc_pkg::CONV_PERIODS - 4'h1) begin
                        st_d = adccc_pkg::ADCCC_IDLE;
                        evt_d.done = 1'b1;
                        evt_d.result = sar_code;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            adccc_pkg::ADCCC_HOLDOFF: begin
                if (tick) begin
                    if (cnt_q == adccc_pkg::ABORT_WAIT_PERIODS - 4'h1) begin
                        st_d = adccc_pkg::ADCCC_IDLE;
                        evt_d.abort_done = 1'b1;
                    end else begin
                        cnt_d = cnt_q + 4'h1;
                    end
                end
            end
            default: st_d = adccc_pkg::ADCCC_IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= adccc_pkg::ADCCC_IDLE;
            cnt_q <= '0;
            evt <= '0;
            busy <= 1'b0;
            acquiring <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            evt <= evt_d;
            busy <= (st_d == adccc_pkg::ADCCC_CONVERT);
            acquiring <= (st_d == adccc_pkg::ADCCC_IDLE);
        end
    end
endmodule // adccc_seq
`default_nettype wire

// ---- rtl/adccc_top.sv ----
// Purpose: Control of a 10-bit successive-approximation converter.
// Assumes: Pin levels and the converter code are synchronous inputs.
// Notes: Registers are 8 bits wide on a plain strobe port.
// Behaviour
// - An output-driven selected pin converts the driver's own level.
// - Channel and direction bits never gate the sequencer.
// - Port reads return zero on analog-configured pins.
// - Digital-configured pins may still be selected and converted.
// - Clearing go during a conversion aborts it at once.
// - Abort leaves the result pair untouched.
// - After abort wait two bit periods before acquiring.
// - After that wait acquisition restarts automatically.
// - Trigger starts conversion only in mode 1011 with power on.
// - Trigger sets go and clears the timer counter.
// - Power off ignores trigger but timer still clears.
// - Clock select maps codes to 2..64 periods or RC.
// - A conversion lasts twelve bit periods.
// - Completion loads result, clears go, sets done flag.
// - Justify bit picks right or left result alignment.
//
// The placing of the registers and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module adccc_top (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] port_a_pins,
    input wire logic [7:0] port_e_pins,
    input wire logic special_event_trigger,
    input wire logic rc_osc,
    input wire logic [9:0] sar_code,
    output logic timer_clear,
    output logic [2:0] channel_select,
    output logic sample_enable,
    output logic conv_active,
    output logic conv_done_irq
);
    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d, cfg_q, cfg_d;
    logic [7:0] res_hi_q, res_hi_d, res_lo_q, res_lo_d;
    logic [7:0] flags_q, flags_d, en_q, en_d, prio_q, prio_d;
    logic [7:0] dir_a_q, dir_a_d, dir_e_q, dir_e_d;
    logic [3:0] cmp2_q, cmp2_d;
    logic [7:0] rdata_d;
    logic timer_clear_d;
    adccc_pkg::adccc_bus_t bus;
    adccc_pkg::adccc_evt_t evt;
    logic tick, busy, acquiring, start, abort, trig_ok, go_q;
    logic [7:0] analog_mask;

    assign bus = '{wdata: reg_wdata, addr: reg_addr, wr: reg_wr, rd: reg_rd};
    assign go_q = ctrl_q[adccc_pkg::CTRL_GO_BIT];

    // Analog pin map per port configuration code; bit n is channel n.
    function automatic logic [7:0] analog_of(input logic [3:0] pcfg);
        unique case (pcfg)
            4'h0, 4'h1, 4'h8: analog_of = 8'hff;
            4'h2, 4'h3: analog_of = 8'h1f;
            4'h4, 4'h5: analog_of = 8'h0b;
            4'h6, 4'h7: analog_of = 8'h00;
            4'h9, 4'ha, 4'hb: analog_of = 8'h3f;
            4'hc: analog_of = 8'h1f;
            4'hd: analog_of = 8'h0f;
            4'he, 4'hf: analog_of = 8'h01;
            default: analog_of = 8'h00;
        endcase
    endfunction

    assign analog_mask = analog_of(cfg_q[3:0]);

    // ----------------------------------------------------------------
    // Conversion start and abort
    // ----------------------------------------------------------------
    // trigger qualification
    assign trig_ok = special_event_trigger &&
        cmp2_q == adccc_pkg::CMP2_TRIGGER_MODE &&
        ctrl_q[adccc_pkg::CTRL_POWER_BIT];
    // Go still stands in the cycle the result lands, so done masks start.
    // no channel gating
    assign start = go_q && !busy && acquiring && !evt.done;
    assign abort = busy && !go_q;

    adccc_tick_gen #(.DIV_W(6)) u_tick (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .run(ctrl_q[adccc_pkg::CTRL_POWER_BIT]),
        .clk_sel({cfg_q[adccc_pkg::CFG_CLK_HI_BIT],
                  ctrl_q[adccc_pkg::CTRL_CLK_LSB+1:adccc_pkg::CTRL_CLK_LSB]}),
        .rc_osc(rc_osc),
        .tick(tick)
    );

    adccc_seq u_seq (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .tick(tick),
        .start(start),
        .abort(abort),
        .sar_code(sar_code),
        .evt(evt),
        .busy(busy),
        .acquiring(acquiring)
    );

    // ----------------------------------------------------------------
    // Register next state
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_d = ctrl_q;
        cfg_d = cfg_q;
        res_hi_d = res_hi_q;
        res_lo_d = res_lo_q;
        flags_d = flags_q;
        en_d = en_q;
        prio_d = prio_q;
        dir_a_d = dir_a_q;
        dir_e_d = dir_e_q;
        cmp2_d = cmp2_q;
        if (bus.wr) begin
            unique case (bus.addr)
                adccc_pkg::OFS_CTRL: ctrl_d = bus.wdata & 8'hfd;
                adccc_pkg::OFS_CFG: cfg_d = bus.wdata & 8'hcf;
                adccc_pkg::OFS_RES_HI: res_hi_d = bus.wdata;
                adccc_pkg::OFS_RES_LO: res_lo_d = bus.wdata;
                adccc_pkg::OFS_FLAGS: flags_d = bus.wdata;
                adccc_pkg::OFS_ENABLES: en_d = bus.wdata;
                adccc_pkg::OFS_PRIORITY: prio_d = bus.wdata;
                adccc_pkg::OFS_DIR_A: dir_a_d = bus.wdata & 8'h7f;
                adccc_pkg::OFS_DIR_E: dir_e_d = bus.wdata & 8'hf7;
                adccc_pkg::OFS_CMP2_MODE: cmp2_d = bus.wdata[3:0];
                default: ;
            endcase
        end
        if (trig_ok) begin
            ctrl_d[adccc_pkg::CTRL_GO_BIT] = 1'b1;
        end
        if (evt.done) begin
            ctrl_d[adccc_pkg::CTRL_GO_BIT] = 1'b0;
            flags_d[adccc_pkg::FLAG_DONE_BIT] = 1'b1;
            if (cfg_q[adccc_pkg::CFG_JUSTIFY_BIT]) begin
                res_hi_d = {6'h00, evt.result[9:8]};
                res_lo_d = evt.result[7:0];
            end else begin
                res_hi_d = evt.result[9:2];
                res_lo_d = {evt.result[1:0], 6'h00};
            end
        end
        // Power off drops go.
        if (!ctrl_d[adccc_pkg::CTRL_POWER_BIT]) begin
            ctrl_d[adccc_pkg::CTRL_GO_BIT] = 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data and outputs
    // ----------------------------------------------------------------
    always_comb begin
        rdata_d = 8'h00;
        if (bus.rd) begin
            unique case (bus.addr)
                adccc_pkg::OFS_CTRL: rdata_d = ctrl_q;
                adccc_pkg::OFS_CFG: rdata_d = cfg_q;
                adccc_pkg::OFS_RES_HI: rdata_d = res_hi_q;
                adccc_pkg::OFS_RES_LO: rdata_d = res_lo_q;
                adccc_pkg::OFS_FLAGS: rdata_d = flags_q;
                adccc_pkg::OFS_ENABLES: rdata_d = en_q;
                adccc_pkg::OFS_PRIORITY: rdata_d = prio_q;
                adccc_pkg::OFS_PORT_A: rdata_d = port_a_pins & 8'h7f &
                    ~{2'b00, analog_mask[4], 1'b0, analog_mask[3:0]};
                adccc_pkg::OFS_PORT_E: rdata_d = port_e_pins & 8'h07 &
                    ~{5'h00, analog_mask[7:5]};
                adccc_pkg::OFS_DIR_A: rdata_d = dir_a_q;
                adccc_pkg::OFS_DIR_E: rdata_d = dir_e_q;
                adccc_pkg::OFS_CMP2_MODE: rdata_d = {4'h0, cmp2_q};
                default: rdata_d = 8'h00;
            endcase
        end
    end

    assign timer_clear_d = special_event_trigger &&
        cmp2_q == adccc_pkg::CMP2_TRIGGER_MODE;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= adccc_pkg::CTRL_RST;
            cfg_q <= adccc_pkg::CFG_RST;
            res_hi_q <= 8'h00;
            res_lo_q <= 8'h00;
            flags_q <= adccc_pkg::IRQ_RST;
            en_q <= adccc_pkg::IRQ_RST;
            prio_q <= adccc_pkg::IRQ_RST;
            dir_a_q <= adccc_pkg::DIR_A_RST;
            dir_e_q <= adccc_pkg::DIR_E_RST;
            cmp2_q <= adccc_pkg::CMP2_MODE_RST;
            reg_rdata <= 8'h00;
            timer_clear <= 1'b0;
            channel_select <= 3'h0;
            sample_enable <= 1'b0;
            conv_active <= 1'b0;
            conv_done_irq <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            cfg_q <= cfg_d;
            res_hi_q <= res_hi_d;
            res_lo_q <= res_lo_d;
            flags_q <= flags_d;
            en_q <= en_d;
            prio_q <= prio_d;
            dir_a_q <= dir_a_d;
            dir_e_q <= dir_e_d;
            cmp2_q <= cmp2_d;
            reg_rdata <= rdata_d;
            timer_clear <= timer_clear_d;
            channel_select <= ctrl_d[adccc_pkg::CTRL_CHAN_LSB+2:
                                     adccc_pkg::CTRL_CHAN_LSB];
            sample_enable <= acquiring && ctrl_d[adccc_pkg::CTRL_POWER_BIT];
            conv_active <= busy;
            conv_done_irq <= flags_d[adccc_pkg::FLAG_DONE_BIT] &
                en_d[adccc_pkg::FLAG_DONE_BIT];
        end
    end
endmodule // adccc_top
`default_nettype wire

// ---- dv/adccc_analog_model.sv ----
// Purpose: Analog pins and converter core beside the control block.
// Assumes: During a conversion the code depends only on the selected channel.
// Notes: Outside a conversion the code is inverted, never held.
`timescale 1ns/1ps
`default_nettype none
module adccc_analog_model (
    input wire logic [2:0] channel_select,
    input wire logic conv_active,
    output logic [9:0] sar_code,
    output logic [7:0] port_a_pins,
    output logic [7:0] port_e_pins
);
    assign sar_code = conv_active ? {channel_select, 7'h2b}
                                  : ~{channel_select, 7'h2b};
    assign port_a_pins = 8'h7f;
    assign port_e_pins = 8'h07;
endmodule // adccc_analog_model
`default_nettype wire

// ---- dv/adccc_properties.sv ----
// Purpose: Port-level checks of the converter control block.
// Assumes: One clock domain; bound to the top module.
// Notes: The length bound allows the slowest divider plus slack.
`timescale 1ns/1ps
`default_nettype none
module adccc_properties (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] port_a_pins,
    input wire logic special_event_trigger,
    input wire logic timer_clear,
    input wire logic [2:0] channel_select,
    input wire logic sample_enable,
    input wire logic conv_active
);
    localparam int MAX_CONV = 800;
    logic ctrl_wr;
    logic abort;
    logic [10:0] len_q;
    logic [10:0] len_d;
    logic [3:0] pcfg_q;
    logic [3:0] pcfg_d;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    assign ctrl_wr = reg_wr && reg_addr == adccc_pkg::OFS_CTRL;
    assign abort = ctrl_wr && !reg_wdata[2] && conv_active;
    always_comb begin
        len_d = conv_active ? len_q + 11'h1 : 11'h0;
        pcfg_d = (reg_wr && reg_addr == adccc_pkg::OFS_CFG) ?
            reg_wdata[3:0] : pcfg_q;
    end
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            len_q <= 11'h0;
            pcfg_q <= 4'h0;
        end else begin
            len_q <= len_d;
            pcfg_q <= pcfg_d;
        end
    end
    AST_RD_IDLE:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside read slot");
    AST_PORT_A_MASK:
        assert property (reg_rd && reg_addr == adccc_pkg::OFS_PORT_A |=>
            (reg_rdata & ~$past(port_a_pins)) == 8'h00 &&
            ($past(pcfg_q) != 4'h0 || (reg_rdata & 8'h2f) == 8'h00))
        else $error("port read shows a bit the pin lacks");
    AST_CHAN_FOLLOW:
        assert property (ctrl_wr ##1 !ctrl_wr |=>
            channel_select == $past(reg_wdata[5:3], 2))
        else $error("channel select not taken from control");
    AST_ABORT_STOP:
        assert property (abort |-> ##[1:3] !conv_active)
        else $error("conversion kept running after abort");
    AST_ABORT_HOLD:
        assert property (abort |=> !sample_enable [*2])
        else $error("acquisition restarted without holdoff");
    AST_ABORT_RESUME:
        assert property (abort && reg_wdata[0] |-> ##[1:200] sample_enable)
        else $error("acquisition did not resume after abort");
    AST_TCLR_CAUSE:
        assert property (timer_clear |-> $past(special_event_trigger))
        else $error("timer clear without trigger");
    AST_TCLR_PULSE:
        assert property (timer_clear |=> !timer_clear)
        else $error("timer clear longer than one cycle");
    AST_ACQ_EXCL:
        assert property (!(sample_enable && conv_active))
        else $error("acquiring while converting");
    AST_CONV_MAX:
        assert property (len_q <= MAX_CONV)
        else $error("conversion too long");
endmodule // adccc_properties
bind adccc_top adccc_properties u_props (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .port_a_pins(port_a_pins),
    .special_event_trigger(special_event_trigger),
    .timer_clear(timer_clear),
    .channel_select(channel_select),
    .sample_enable(sample_enable),
    .conv_active(conv_active)
);
`default_nettype wire

// ---- dv/adccc_tb.sv ----
// Purpose: Self-checking bench for the converter control block.
// Assumes: The analog model supplies pins and the converter code.
// Notes: The RC source toggles every 4 clocks, a bit period of 8.
`timescale 1ns/1ps
`default_nettype none
module adccc_tb;
    localparam logic [3:0] RA [9] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h6,
                                     4'h9, 4'ha, 4'hb, 4'hc};
    localparam logic [7:0] RV [9] = '{8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, adccc_pkg::DIR_A_RST, adccc_pkg::DIR_E_RST, 8'h00, 8'h00};
    localparam logic [3:0] AA [5] = '{4'h1, 4'h9, 4'ha, 4'hb, 4'hc};
    localparam logic [7:0] AV [5] = '{8'hcf, 8'h7f, 8'hf7, 8'h0f, 8'h00};
    localparam logic [7:0] PC [3] = '{8'h00, 8'h06, 8'h04};
    localparam logic [7:0] PA [3] = '{8'h50, 8'h7f, 8'h74};
    localparam logic [7:0] PE [3] = '{8'h00, 8'h07, 8'h07};
    localparam logic [2:0] CODES [8] = '{3'h0, 3'h4, 3'h1, 3'h5,
                                         3'h2, 3'h6, 3'h3, 3'h7};
    localparam int DIVS [8] = '{2, 4, 8, 16, 32, 64, 8, 8};
    localparam logic [7:0] TM [3] = '{8'h0b, 8'h00, 8'h0b};
    localparam logic [7:0] TC [3] = '{8'h00, 8'h01, 8'h01};
    localparam logic [7:0] TX [3] = '{8'h01, 8'h00, 8'h01};
    localparam logic [7:0] TV [3] = '{8'h00, 8'h00, 8'h01};
    logic core_clk;
    logic rst_b;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [7:0] reg_rdata;
    logic [7:0] port_a_pins;
    logic [7:0] port_e_pins;
    logic special_event_trigger;
    logic rc_osc = 1'b0;
    logic [1:0] rc_cnt = 2'h0;
    logic [9:0] sar_code;
    logic timer_clear;
    logic [2:0] channel_select;
    logic sample_enable;
    logic conv_active;
    logic conv_done_irq;
    logic [7:0] ctl;
    logic [9:0] ec;
    logic jr;
    int n;
    int err_total;
    int cmp_count;
    adccc_top u_dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .port_a_pins(port_a_pins),
        .port_e_pins(port_e_pins),
        .special_event_trigger(special_event_trigger),
        .rc_osc(rc_osc),
        .sar_code(sar_code),
        .timer_clear(timer_clear),
        .channel_select(channel_select),
        .sample_enable(sample_enable),
        .conv_active(conv_active),
        .conv_done_irq(conv_done_irq)
    );
    adccc_analog_model u_model (
        .channel_select(channel_select),
        .conv_active(conv_active),
        .sar_code(sar_code),
        .port_a_pins(port_a_pins),
        .port_e_pins(port_e_pins)
    );
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        rc_cnt <= rc_cnt + 2'h1;
        if (rc_cnt == 2'h3) begin
            rc_osc <= ~rc_osc;
        end
    end
    task automatic chk(input string w, input logic [7:0] e,
                       input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("Error %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic chk_rng(input string w, input int lo, input int hi,
                           input int g);
        cmp_count++;
        if (g < lo || g > hi) begin
            err_total++;
            $display("Error %s expected %0d..%0d seen %0d", w, lo, hi, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input string w, input logic [3:0] a,
                      input logic [7:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        chk(w, e, reg_rdata);
    endtask
    // Waits briefly for a start, then counts the busy cycles.
    // The bus stays quiet meanwhile, as software asleep would.
    task automatic conv_len(output int c);
        c = 0;
        repeat (10) begin
            if (conv_active !== 1'b1) @(negedge core_clk);
        end
        while (conv_active === 1'b1 && c < 2000) begin
            @(negedge core_clk);
            c++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("Error watchdog expected finish seen timeout");
        tally_and_finish();
    end
    initial begin
        {rst_b, reg_addr, reg_wdata, reg_wr, reg_rd} = '0;
        special_event_trigger = 1'b0;
        err_total = 0;
        cmp_count = 0;
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 9; i++) rd("reset value", RA[i], RV[i]);
        for (int i = 0; i < 5; i++) wr(AA[i], 8'hff);
        for (int i = 0; i < 5; i++) rd("access", AA[i], AV[i]);
        $display("test registers done");
        for (int i = 0; i < 3; i++) begin
            wr(4'h1, PC[i]);
            rd("port a", 4'h7, PA[i]);
            rd("port e", 4'h8, PE[i]);
        end
        $display("test ports done");
        wr(4'h9, 8'h00);
        wr(4'h5, 8'h40);
        for (int i = 0; i < 8; i++) begin
            jr = i[0];
            ctl = {CODES[i][1:0], i[2:0], 3'h1};
            ec = {i[2:0], 7'h2b};
            wr(4'h1, {jr, CODES[i][2], 6'h00});
            wr(4'h0, ctl);
            wr(4'h0, ctl | 8'h04);
            conv_len(n);
            chk_rng("cycles", 11 * DIVS[i], 13 * DIVS[i] + 8, n);
            rd("ctrl", 4'h0, ctl);
            rd("flags", 4'h4, 8'h40);
            chk("irq", 8'h01, {7'h00, conv_done_irq});
            rd("hi", 4'h2, jr ? {6'h00, ec[9:8]} : ec[9:2]);
            rd("lo", 4'h3, jr ? ec[7:0] : {ec[1:0], 6'h00});
            wr(4'h4, 8'h00);
        end
        $display("test conversions done");
        wr(4'h2, 8'h12);
        wr(4'h3, 8'h34);
        wr(4'h1, 8'h40);
        wr(4'h0, 8'h81);
        wr(4'h0, 8'h85);
        repeat (100) @(posedge core_clk);
        wr(4'h0, 8'h81);
        n = 0;
        while (sample_enable !== 1'b1 && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        chk_rng("holdoff", 60, 140, n);
        rd("hi kept", 4'h2, 8'h12);
        rd("lo kept", 4'h3, 8'h34);
        rd("no done", 4'h4, 8'h00);
        $display("test abort done");
        wr(4'h1, 8'h00);
        wr(4'h9, 8'h7f);
        for (int i = 0; i < 3; i++) begin
            wr(4'hb, TM[i]);
            wr(4'h0, TC[i]);
            repeat (8) @(posedge core_clk);
            special_event_trigger <= 1'b1;
            @(posedge core_clk);
            special_event_trigger <= 1'b0;
            @(negedge core_clk);
            chk("timer clear", TX[i], {7'h00, timer_clear});
            repeat (3) @(negedge core_clk);
            chk("trig start", TV[i], {7'h00, conv_active});
            conv_len(n);
            wr(4'h4, 8'h00);
        end
        $display("test trigger done");
        tally_and_finish();
    end
endmodule // adccc_tb
`default_nettype wire
